//--- hwm_pkg.sv
// package for the hardware monitor interrupt and temperature readout block
// assumes a byte-wide register port and one 100 MHz clock
package hwm_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;

    // register offsets
    localparam logic [7:0] REG_REMOTE1_READ  = 8'h25;
    localparam logic [7:0] REG_INTERNAL_READ = 8'h26;
    localparam logic [7:0] REG_REMOTE2_READ  = 8'h27;
    localparam logic [7:0] REG_READY_LOCK    = 8'h40;
    localparam logic [7:0] REG_LIMIT_STS1    = 8'h41;
    localparam logic [7:0] REG_FAULT_STS2    = 8'h42;
    localparam logic [7:0] REG_INT_LOW_LIM   = 8'h50;
    localparam logic [7:0] REG_INT_HIGH_LIM  = 8'h51;
    localparam logic [7:0] REG_REM1_LOW_LIM  = 8'h52;
    localparam logic [7:0] REG_REM1_HIGH_LIM = 8'h53;
    localparam logic [7:0] REG_REM2_LOW_LIM  = 8'h54;
    localparam logic [7:0] REG_REM2_HIGH_LIM = 8'h55;
    localparam logic [7:0] REG_SPECIAL_FUNC  = 8'h7c;
    localparam logic [7:0] REG_IRQ_EN_INDIV  = 8'h7e;
    localparam logic [7:0] REG_FAN_IRQ_EN    = 8'h80;
    localparam logic [7:0] REG_TEMP_IRQ_EN   = 8'h82;
    localparam logic [7:0] REG_HOST_ROUTE    = 8'h84;
    localparam logic [7:0] REG_HOST_STATUS   = 8'h85;

    // field positions
    localparam int unsigned BIT_START     = 0;
    localparam int unsigned BIT_LOCK      = 1;
    localparam int unsigned BIT_GROUP_EN  = 0;
    localparam int unsigned BIT_PIN_EN    = 2;
    localparam int unsigned BIT_REM1      = 0;
    localparam int unsigned BIT_INTERNAL  = 1;
    localparam int unsigned BIT_REM2      = 2;
    localparam int unsigned BIT_WAKE_EN   = 0;
    localparam int unsigned BIT_MGMT_EN   = 1;
    localparam int unsigned BIT_MGMT_IRQ2 = 2;
    localparam int unsigned BIT_SERIRQ_EN = 3;
    localparam int unsigned IRQ_SEL_LSB   = 4;
    localparam int unsigned IRQ_SEL_W     = 4;
    localparam int unsigned NUM_FANS      = 3;

    // reset values and codes
    localparam logic [7:0] RST_ZERO      = 8'h00;
    localparam logic [7:0] RST_HIGH_LIM  = 8'h7f;
    localparam logic [7:0] RST_LOW_LIM   = 8'h81;
    localparam logic [7:0] SENSOR_ERROR  = 8'h80;
    localparam logic [7:0] RST_FAN_ERR   = 8'h00;

    typedef struct packed {
        logic             wr;
        logic             rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } hwm_bus_type;

    // one conversion result from the analog front end
    typedef struct packed {
        logic       valid;
        logic [1:0] channel;
        logic       fault;
        logic [7:0] value;
    } hwm_conv_type;

    localparam logic [1:0] CH_REMOTE1  = 2'h0;
    localparam logic [1:0] CH_INTERNAL = 2'h1;
    localparam logic [1:0] CH_REMOTE2  = 2'h2;

    typedef enum logic [0:0] {
        MODE_SLEEP,
        MODE_MONITOR
    } hwm_mode_type;
endpackage : hwm_pkg

//--- hwm_irq_temp.sv
// hardware monitor interrupt routing, sleep control and temperature readout
// assumes conversions arrive as one-cycle results; host paths are level outputs
//
// Contract
// [R1] temperature events reach any output only with temperature group enable set
// [R2] fan tach events reach outputs only with fan group enable set
// [R3] interrupt pin driven active only with global pin enable set
// [R4] pin tristated while global pin enable is clear
// [R5] limit violation drives pin low while matching enabled status bit stays set
// [R6] diode fault loads error code, which then trips the limit error bit
// [R7] pin low while any enabled status bit is set; diode fault bits 0 and 2 of status two do not drive it
// [R8] status read attempts clearing; bits with active cause stay set
// [R9] software clears pin enable around status reads, then rewrites it
// [R10] pin never active outside monitoring mode
// [R11] wake thermal status sets on group-enabled events, ignoring pin enable
// [R12] management thermal status sets on group-enabled events, ignoring pin enable
// [R13] management interrupt onto serial irq slot two only when enabled
// [R14] monitor interrupt sent on selected serial irq frame, ignoring pin enable
// [R15] start bit zero is sleep, one is full monitoring
// [R16] sleep stops conversions; registers stay accessible
// [R17] sleep holds all fan pwm outputs high
// [R18] start bit writes ignored while lock bit set
// [R19] internal reading stored; outside its limits sets internal error bit
// [R20] remote readings stored; limit violation sets remote error bit
// [R21] diode fault sets fault bit and forces reading to error code
// [R22] readings are 8-bit two's complement, 80h reserved for sensor error
// [R23] status bit clears on write-one only when cause has gone
// [R24] status bit never sets while its individual enable is clear
// [R25] status registers reset to zero
// [R26] combined event is or of status bits with group enable set; code leaves out diode fault bits 0 and 2 of status two
`timescale 1ns/10ps
`default_nettype none
module hwm_irq_temp #(
    parameter int unsigned NUM_FAN = hwm_pkg::NUM_FANS
) (
    input  wire logic                     clk,
    input  wire logic                     rst,
    input  wire hwm_pkg::hwm_bus_type     bus,
    output var  logic [hwm_pkg::DATA_W-1:0] rdata,
    input  wire hwm_pkg::hwm_conv_type    conv,
    input  wire logic [NUM_FAN-1:0]       fanTachError,
    output var  logic                     convEnable,
    output var  logic [NUM_FAN-1:0]       pwmForceHigh,
    output var  logic                     monitorIrqN,
    output var  logic                     monitorIrqOe,
    output var  logic                     wakeThermalSts,
    output var  logic                     mgmtThermalSts,
    output var  logic                     mgmtSerirqSlot2,
    output var  logic                     serirqReq,
    output var  logic [hwm_pkg::IRQ_SEL_W-1:0] serirqFrame
);
    import hwm_pkg::*;

    typedef struct packed {
        logic [7:0]         rem1Read;
        logic [7:0]         intRead;
        logic [7:0]         rem2Read;
        logic               start;
        logic               lock;
        logic [7:0]         sts1;
        logic [7:0]         sts2;
        logic [7:0]         intLow;
        logic [7:0]         intHigh;
        logic [7:0]         rem1Low;
        logic [7:0]         rem1High;
        logic [7:0]         rem2Low;
        logic [7:0]         rem2High;
        logic [7:0]         specialFunc;
        logic [7:0]         indivEn;
        logic [7:0]         fanEn;
        logic [7:0]         tempEn;
        logic [7:0]         hostRoute;
        logic               wakeSts;
        logic               mgmtSts;
        logic [7:0]         rdata;
        logic               irqN;
        logic               irqOe;
        logic               mgmtSlot2;
        logic               serReq;
        logic [NUM_FAN-1:0] pwmHigh;
        logic               convEn;
    } hwm_state_type;

    hwm_state_type state_ff;
    hwm_state_type nxt_state;

    // live causes, used to hold status bits against clears
    logic [7:0] tempCause;
    logic [7:0] faultCause;
    logic [7:0] fanCause;
    logic       tempGroup;
    logic       fanGroup;
    logic       monEvent;
    logic       pinEvent;
    logic       monitoring;
    logic       clearSts1;
    logic       clearSts2;

    // signed compare: violation when at or beyond either limit
    function automatic logic out_of_range(
        input logic [7:0] value,
        input logic [7:0] low,
        input logic [7:0] high
    );
        return ($signed(value) <= $signed(low)) || ($signed(value) >= $signed(high));
    endfunction : out_of_range

    always_comb begin
        monitoring = state_ff.start;
        tempGroup  = state_ff.tempEn[BIT_GROUP_EN];
        fanGroup   = state_ff.fanEn[BIT_GROUP_EN];
        tempCause  = RST_ZERO;
        faultCause = RST_ZERO;
        fanCause   = RST_FAN_ERR;
        tempCause[BIT_REM1] = out_of_range(state_ff.rem1Read, state_ff.rem1Low,
                                           state_ff.rem1High);
        tempCause[BIT_INTERNAL] = out_of_range(state_ff.intRead, state_ff.intLow,
                                               state_ff.intHigh);
        tempCause[BIT_REM2] = out_of_range(state_ff.rem2Read, state_ff.rem2Low,
                                           state_ff.rem2High);
        // fault cause persists as long as the reading holds the error code
        faultCause[BIT_REM1] = state_ff.rem1Read == SENSOR_ERROR;
        faultCause[BIT_REM2] = state_ff.rem2Read == SENSOR_ERROR;
        fanCause[NUM_FAN-1:0] = fanTachError & state_ff.fanEn[NUM_FAN:1];
        // tach errors sit in bits above the diode fault bits of status two
        monEvent = (tempGroup && (state_ff.sts1 != RST_ZERO)) //R1 R26
                 || (fanGroup && (state_ff.sts2[NUM_FAN+2:3] != '0)); //R2 R26
        pinEvent = monEvent && monitoring; //R7 R10
        clearSts1 = 1'b0;
        clearSts2 = 1'b0;
        if (bus.rd && bus.addr == REG_LIMIT_STS1) begin
            clearSts1 = 1'b1; //R8
        end
        if (bus.rd && bus.addr == REG_FAULT_STS2) begin
            clearSts2 = 1'b1; //R8
        end
    end

    always_comb begin
        nxt_state = state_ff;

        // register writes
        if (bus.wr) begin
            case (bus.addr)
                REG_READY_LOCK: begin
                    if (!state_ff.lock) begin
                        nxt_state.start = bus.wdata[BIT_START]; //R15 R18
                    end
                    // lock is sticky until reset
                    nxt_state.lock = state_ff.lock | bus.wdata[BIT_LOCK];
                end
                REG_LIMIT_STS1:    nxt_state.sts1 = state_ff.sts1 & ~(bus.wdata & ~tempCause); //R23
                REG_FAULT_STS2:    nxt_state.sts2 = state_ff.sts2 &
                                       ~(bus.wdata & ~(faultCause | {fanCause[4:0], 3'h0})); //R23
                REG_INT_LOW_LIM:   nxt_state.intLow = bus.wdata;
                REG_INT_HIGH_LIM:  nxt_state.intHigh = bus.wdata;
                REG_REM1_LOW_LIM:  nxt_state.rem1Low = bus.wdata;
                REG_REM1_HIGH_LIM: nxt_state.rem1High = bus.wdata;
                REG_REM2_LOW_LIM:  nxt_state.rem2Low = bus.wdata;
                REG_REM2_HIGH_LIM: nxt_state.rem2High = bus.wdata;
                REG_SPECIAL_FUNC:  nxt_state.specialFunc = bus.wdata;
                REG_IRQ_EN_INDIV:  nxt_state.indivEn = bus.wdata;
                REG_FAN_IRQ_EN:    nxt_state.fanEn = bus.wdata;
                REG_TEMP_IRQ_EN:   nxt_state.tempEn = bus.wdata;
                REG_HOST_ROUTE:    nxt_state.hostRoute = bus.wdata;
                REG_HOST_STATUS: begin
                    // write-one clears, but a live event wins
                    nxt_state.wakeSts = state_ff.wakeSts & ~bus.wdata[BIT_WAKE_EN];
                    nxt_state.mgmtSts = state_ff.mgmtSts & ~bus.wdata[BIT_MGMT_EN];
                end
                default: begin
                end
            endcase
        end

        // read-to-clear attempt; live causes keep bits
        if (clearSts1) begin
            nxt_state.sts1 = state_ff.sts1 & tempCause; //R8
        end
        if (clearSts2) begin
            nxt_state.sts2 = state_ff.sts2 & (faultCause | {fanCause[4:0], 3'h0}); //R8
        end

        // conversion results only taken while monitoring
        if (conv.valid && monitoring) begin //R16
            case (conv.channel)
                CH_REMOTE1: begin
                    nxt_state.rem1Read = conv.fault ? SENSOR_ERROR : conv.value; //R21 R22
                    if (conv.fault && state_ff.indivEn[BIT_REM1]) begin
                        nxt_state.sts2[BIT_REM1] = 1'b1; //R21 R24
                    end
                end
                CH_INTERNAL: nxt_state.intRead = conv.value; //R19 R22
                CH_REMOTE2: begin
                    nxt_state.rem2Read = conv.fault ? SENSOR_ERROR : conv.value; //R20 R21
                    if (conv.fault && state_ff.indivEn[BIT_REM2]) begin
                        nxt_state.sts2[BIT_REM2] = 1'b1; //R21 R24
                    end
                end
                default: begin
                end
            endcase
        end

        // status sets win over clears, only for individually enabled sources
        if (monitoring) begin
            nxt_state.sts1 = nxt_state.sts1 | (tempCause & state_ff.indivEn); //R5 R6 R19 R20 R24
            nxt_state.sts2[NUM_FAN+2:3] = nxt_state.sts2[NUM_FAN+2:3] | fanCause[NUM_FAN-1:0]; //R24
        end

        // host-side event paths, unaffected by pin enable
        if (monEvent) begin
            nxt_state.wakeSts = 1'b1; //R11
            nxt_state.mgmtSts = 1'b1; //R12
        end
        nxt_state.mgmtSlot2 = state_ff.mgmtSts && state_ff.hostRoute[BIT_MGMT_EN]
                              && state_ff.hostRoute[BIT_MGMT_IRQ2]; //R13
        nxt_state.serReq = monEvent && state_ff.hostRoute[BIT_SERIRQ_EN]; //R14

        // interrupt pin: open drain, low only while enabled and monitoring
        nxt_state.irqOe = state_ff.specialFunc[BIT_PIN_EN] && pinEvent; //R3 R4 R5 R7 R9 R10
        nxt_state.irqN = !nxt_state.irqOe; //R3

        nxt_state.convEn = monitoring; //R15 R16
        nxt_state.pwmHigh = monitoring ? '0 : '1; //R17

        // read data, one cycle after the strobe
        nxt_state.rdata = RST_ZERO;
        if (bus.rd) begin
            case (bus.addr)
                REG_REMOTE1_READ:  nxt_state.rdata = state_ff.rem1Read;
                REG_INTERNAL_READ: nxt_state.rdata = state_ff.intRead;
                REG_REMOTE2_READ:  nxt_state.rdata = state_ff.rem2Read;
                REG_READY_LOCK: begin
                    nxt_state.rdata[BIT_START] = state_ff.start;
                    nxt_state.rdata[BIT_LOCK] = state_ff.lock;
                end
                REG_LIMIT_STS1:    nxt_state.rdata = state_ff.sts1;
                REG_FAULT_STS2:    nxt_state.rdata = state_ff.sts2;
                REG_INT_LOW_LIM:   nxt_state.rdata = state_ff.intLow;
                REG_INT_HIGH_LIM:  nxt_state.rdata = state_ff.intHigh;
                REG_REM1_LOW_LIM:  nxt_state.rdata = state_ff.rem1Low;
                REG_REM1_HIGH_LIM: nxt_state.rdata = state_ff.rem1High;
                REG_REM2_LOW_LIM:  nxt_state.rdata = state_ff.rem2Low;
                REG_REM2_HIGH_LIM: nxt_state.rdata = state_ff.rem2High;
                REG_SPECIAL_FUNC:  nxt_state.rdata = state_ff.specialFunc;
                REG_IRQ_EN_INDIV:  nxt_state.rdata = state_ff.indivEn;
                REG_FAN_IRQ_EN:    nxt_state.rdata = state_ff.fanEn;
                REG_TEMP_IRQ_EN:   nxt_state.rdata = state_ff.tempEn;
                REG_HOST_ROUTE:    nxt_state.rdata = state_ff.hostRoute;
                REG_HOST_STATUS: begin
                    nxt_state.rdata[BIT_WAKE_EN] = state_ff.wakeSts;
                    nxt_state.rdata[BIT_MGMT_EN] = state_ff.mgmtSts;
                end
                default: nxt_state.rdata = RST_ZERO;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_ff <= '0; //R25
            state_ff.intLow <= RST_LOW_LIM;
            state_ff.intHigh <= RST_HIGH_LIM;
            state_ff.rem1Low <= RST_LOW_LIM;
            state_ff.rem1High <= RST_HIGH_LIM;
            state_ff.rem2Low <= RST_LOW_LIM;
            state_ff.rem2High <= RST_HIGH_LIM;
            state_ff.irqN <= 1'b1;
            state_ff.pwmHigh <= '1;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_comb begin
        rdata           = state_ff.rdata;
        convEnable      = state_ff.convEn;
        pwmForceHigh    = state_ff.pwmHigh;
        monitorIrqN     = state_ff.irqN;
        monitorIrqOe    = state_ff.irqOe;
        wakeThermalSts  = state_ff.wakeSts;
        mgmtThermalSts  = state_ff.mgmtSts;
        mgmtSerirqSlot2 = state_ff.mgmtSlot2;
        serirqReq       = state_ff.serReq;
        serirqFrame     = state_ff.hostRoute[IRQ_SEL_LSB +: IRQ_SEL_W];
    end
endmodule : hwm_irq_temp
`default_nettype wire

//--- hwm_irq_temp_props.sv
// port checker for hwm_irq_temp
// assumes only the top ports; pin enable and lock are rebuilt from bus writes
`timescale 1ns/10ps
`default_nettype none
module hwm_irq_temp_props
    import hwm_pkg::*;
#(
    parameter int unsigned NUM_FAN = hwm_pkg::NUM_FANS
) (
    input wire logic                 clk,
    input wire logic                 rst,
    input wire hwm_pkg::hwm_bus_type bus,
    input wire logic                 convEnable,
    input wire logic [NUM_FAN-1:0]   pwmForceHigh,
    input wire logic                 monitorIrqN,
    input wire logic                 monitorIrqOe,
    input wire logic                 wakeThermalSts,
    input wire logic                 mgmtThermalSts
);
    logic pinEn_ff;
    logic lock_ff;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // shadows only; lock is sticky like the real one
    always_ff @(posedge clk) begin
        if (rst) begin
            pinEn_ff <= 1'b0;
            lock_ff  <= 1'b0;
        end else if (bus.wr && bus.addr == REG_SPECIAL_FUNC) begin
            pinEn_ff <= bus.wdata[BIT_PIN_EN];
        end else if (bus.wr && bus.addr == REG_READY_LOCK && !lock_ff) begin
            lock_ff  <= bus.wdata[BIT_LOCK];
        end
    end
    property p_sleep_pwm;
        !convEnable |-> &pwmForceHigh;
    endproperty
    a_sleep_pwm: assert property (p_sleep_pwm) else $error("pwm not forced in sleep");
    property p_sleep_quiet;
        !convEnable && $past(!convEnable) |-> !monitorIrqOe;
    endproperty
    a_sleep_quiet: assert property (p_sleep_quiet) else $error("pin active in sleep");
    property p_pin_needs_en;
        monitorIrqOe |-> $past(pinEn_ff);
    endproperty
    a_pin_needs_en: assert property (p_pin_needs_en) else $error("pin without enable");
    property p_tristate;
        !monitorIrqOe |-> monitorIrqN;
    endproperty
    a_tristate: assert property (p_tristate) else $error("pin low while released");
    property p_drive_low;
        monitorIrqOe |-> !monitorIrqN;
    endproperty
    a_drive_low: assert property (p_drive_low) else $error("pin driven high");
    property p_lock_hold;
        lock_ff && $past(lock_ff, 2) && bus.wr && bus.addr == REG_READY_LOCK
            |=> $stable(convEnable) [*2];
    endproperty
    a_lock_hold: assert property (p_lock_hold) else $error("mode changed under lock");
    property p_wake_sticky;
        wakeThermalSts && !(bus.wr && bus.addr == REG_HOST_STATUS && bus.wdata[0])
            |=> wakeThermalSts;
    endproperty
    a_wake_sticky: assert property (p_wake_sticky) else $error("wake status lost");
    property p_mgmt_sticky;
        mgmtThermalSts && !(bus.wr && bus.addr == REG_HOST_STATUS && bus.wdata[1])
            |=> mgmtThermalSts;
    endproperty
    a_mgmt_sticky: assert property (p_mgmt_sticky) else $error("mgmt status lost");
endmodule : hwm_irq_temp_props
bind hwm_irq_temp hwm_irq_temp_props #(.NUM_FAN(NUM_FAN)) i_props (.clk(clk), .rst(rst),
    .bus(bus), .convEnable(convEnable), .pwmForceHigh(pwmForceHigh),
    .monitorIrqN(monitorIrqN), .monitorIrqOe(monitorIrqOe),
    .wakeThermalSts(wakeThermalSts), .mgmtThermalSts(mgmtThermalSts));
`default_nettype wire

//--- hwm_host_model.sv
// host side: board pull-up on the pin and a serial irq frame catcher
// assumes one clock shared with the monitor
`timescale 1ns/10ps
`default_nettype none
module hwm_host_model (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       monitorIrqN,
    input wire logic       monitorIrqOe,
    input wire logic       serirqReq,
    input wire logic [3:0] serirqFrame,
    output logic           pinLevel,
    output logic [3:0]     frame_ff
);
    // released line floats to the pull-up, never the last value
    assign pinLevel = monitorIrqOe ? monitorIrqN : 1'b1;
    always_ff @(posedge clk) begin
        if (rst) begin
            frame_ff <= 4'h0;
        end else if (serirqReq) begin
            frame_ff <= serirqFrame;
        end
    end
endmodule : hwm_host_model
`default_nettype wire

//--- hwm_irq_temp_tb.sv
// bench for hwm_irq_temp: register tasks, conversions, pin and host paths
// assumes a 100 MHz clock and the host model on the far side
`timescale 1ns/10ps
`default_nettype none
module hwm_irq_temp_tb;
    import hwm_pkg::*;
    logic clk = 1'b0, rst = 1'b1;
    hwm_bus_type bus = '0;
    hwm_conv_type conv = '0;
    logic [2:0] fanTachError = 3'h0, pwmForceHigh;
    logic [3:0] serirqFrame, frame_ff;
    logic [7:0] rdata;
    logic convEnable, monitorIrqN, monitorIrqOe, wakeThermalSts, mgmtThermalSts;
    logic mgmtSerirqSlot2, serirqReq, pinLevel;
    int n_errors = 0, compares = 0;
    always #5 clk = ~clk;
    hwm_irq_temp i_dut (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata), .conv(conv),
        .fanTachError(fanTachError), .convEnable(convEnable), .pwmForceHigh(pwmForceHigh),
        .monitorIrqN(monitorIrqN), .monitorIrqOe(monitorIrqOe),
        .wakeThermalSts(wakeThermalSts), .mgmtThermalSts(mgmtThermalSts),
        .mgmtSerirqSlot2(mgmtSerirqSlot2), .serirqReq(serirqReq), .serirqFrame(serirqFrame));
    hwm_host_model i_host (.clk(clk), .rst(rst), .monitorIrqN(monitorIrqN),
        .monitorIrqOe(monitorIrqOe), .serirqReq(serirqReq), .serirqFrame(serirqFrame),
        .pinLevel(pinLevel), .frame_ff(frame_ff));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk);
        bus.rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask : rdc
    task automatic cv(input logic [1:0] ch, input logic f, input logic [7:0] v);
        @(posedge clk);
        conv <= '{valid: 1'b1, channel: ch, fault: f, value: v};
        @(posedge clk);
        conv.valid <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
    endtask : cv
    // settle first: a wrong clear shows one edge after the write
    // look just after each edge, never in the edge's own time step
    task automatic pin(input logic expOe);
        repeat (3) @(posedge clk);
        #1;
        for (int i = 0; i < 20 && monitorIrqOe !== expOe; i++) begin
            @(posedge clk);
            #1;
        end
        chk({7'h0, monitorIrqOe}, {7'h0, expOe});
        chk({7'h0, pinLevel}, {7'h0, ~expOe});
    endtask : pin
    task automatic end_sim;
        $display("compares=%0d n_errors=%0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_sim
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        end_sim();
    end
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rdc(REG_LIMIT_STS1, 8'h00);
        rdc(REG_FAULT_STS2, 8'h00);
        rdc(REG_INT_LOW_LIM, 8'h81);
        rdc(8'h10, 8'h00);
        chk({5'h0, pwmForceHigh}, 8'h07);
        wr(REG_IRQ_EN_INDIV, 8'h05);
        wr(REG_TEMP_IRQ_EN, 8'h01);
        wr(REG_FAN_IRQ_EN, 8'h0f);
        wr(REG_SPECIAL_FUNC, 8'h04);
        cv(CH_REMOTE2, 1'b0, 8'h7f);
        rdc(REG_LIMIT_STS1, 8'h00);
        wr(REG_READY_LOCK, 8'h01);
        cv(CH_INTERNAL, 1'b0, 8'h7f);
        chk({7'h0, convEnable}, 8'h01);
        rdc(REG_LIMIT_STS1, 8'h00);
        wr(REG_INT_HIGH_LIM, 8'h30);
        wr(REG_IRQ_EN_INDIV, 8'h07);
        cv(CH_INTERNAL, 1'b0, 8'h30);
        rdc(REG_INTERNAL_READ, 8'h30);
        pin(1'b1);
        chk({6'h0, wakeThermalSts, mgmtThermalSts}, 8'h03);
        cv(CH_INTERNAL, 1'b0, 8'h10);
        wr(REG_LIMIT_STS1, 8'h00);
        pin(1'b1);
        wr(REG_LIMIT_STS1, 8'h02);
        pin(1'b0);
        cv(CH_INTERNAL, 1'b0, 8'h30);
        rdc(REG_LIMIT_STS1, 8'h02);
        rdc(REG_LIMIT_STS1, 8'h02);
        wr(REG_TEMP_IRQ_EN, 8'h00);
        pin(1'b0);
        wr(REG_HOST_STATUS, 8'h03);
        rdc(REG_HOST_STATUS, 8'h00);
        // host paths must set again with the pin enable already off
        wr(REG_SPECIAL_FUNC, 8'h00);
        wr(REG_TEMP_IRQ_EN, 8'h01);
        pin(1'b0);
        wr(REG_HOST_ROUTE, 8'h5e);
        repeat (3) @(posedge clk);
        #1 chk({serirqFrame, 1'b0, serirqReq, mgmtSerirqSlot2, mgmtThermalSts}, 8'h57);
        chk({7'h0, wakeThermalSts}, 8'h01);
        chk({4'h0, frame_ff}, 8'h05);
        wr(REG_HOST_ROUTE, 8'h5a);
        repeat (3) @(posedge clk);
        #1 chk({7'h0, mgmtSerirqSlot2}, 8'h00);
        wr(REG_SPECIAL_FUNC, 8'h04);
        pin(1'b1);
        cv(CH_INTERNAL, 1'b0, 8'h10);
        rdc(REG_LIMIT_STS1, 8'h02);
        rdc(REG_LIMIT_STS1, 8'h00);
        @(posedge clk) fanTachError <= 3'h1;
        pin(1'b1);
        wr(REG_FAN_IRQ_EN, 8'h0e);
        pin(1'b0);
        @(posedge clk) fanTachError <= 3'h0;
        rdc(REG_FAULT_STS2, 8'h08);
        rdc(REG_FAULT_STS2, 8'h00);
        cv(CH_REMOTE1, 1'b1, 8'h05);
        rdc(REG_REMOTE1_READ, 8'h80);
        rdc(REG_FAULT_STS2, 8'h01);
        cv(CH_REMOTE2, 1'b0, 8'h7f);
        rdc(REG_REMOTE2_READ, 8'h7f);
        rdc(REG_LIMIT_STS1, 8'h05);
        wr(REG_READY_LOCK, 8'h00);
        pin(1'b0);
        chk({4'h0, convEnable, pwmForceHigh}, 8'h07);
        rdc(REG_REMOTE2_READ, 8'h7f);
        wr(REG_READY_LOCK, 8'h03);
        repeat (3) @(posedge clk);
        wr(REG_READY_LOCK, 8'h00);
        repeat (4) @(posedge clk);
        #1 chk({7'h0, convEnable}, 8'h01);
        end_sim();
    end
endmodule : hwm_irq_temp_tb
`default_nettype wire
